// File: pod_pkg.sv
// Package with register map, field layout, reset values and types of the paired output channel divider.
package pod_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam logic [29:0] POD_IDX_DIV0_CYCLE_COUNTS = 30'h190;
    localparam logic [29:0] POD_IDX_DIV0_BYPASS_CTRL = 30'h191;
    localparam logic [29:0] POD_IDX_DIV0_DUTY_FIX_CTRL = 30'h192;
    localparam logic [29:0] POD_IDX_DIV1_CYCLE_COUNTS = 30'h196;
    localparam logic [29:0] POD_IDX_DIV1_BYPASS_CTRL = 30'h197;
    localparam logic [29:0] POD_IDX_DIV1_DUTY_FIX_CTRL = 30'h198;
    localparam logic [29:0] POD_IDX_STATUS = 30'h1f0;

    // ------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------
    localparam int POD_FLD_W = 4;
    localparam int POD_FLD_HIGH_LSB = 0;
    localparam int POD_FLD_LOW_LSB = 4;
    localparam int POD_FLD_PHASE_LSB = 0;
    localparam int POD_BIT_BEGIN_HIGH = 4;
    localparam int POD_BIT_BYPASS = 7;
    localparam int POD_BIT_CORR_DIS = 0;
    localparam int POD_REG_W = 8;
    localparam int POD_CNT_W = 5;
    localparam logic [7:0] POD_RST_CYCLE_COUNTS = 8'h00;
    localparam logic [7:0] POD_RST_BYPASS_CTRL = 8'h00;
    localparam logic [7:0] POD_RST_DUTY_FIX_CTRL = 8'h00;
    localparam logic [4:0] POD_CNT_ZERO = 5'h00;
    localparam logic [4:0] POD_CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // Bus encodings.
    // ------------------------------------------------------------
    localparam logic [1:0] POD_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] POD_HSIZE_WORD = 3'h2;
    localparam logic POD_HRESP_OKAY = 1'b0;

    // Register kind within one divider.
    typedef enum logic [1:0] {
        POD_KIND_COUNTS,
        POD_KIND_BYPASS,
        POD_KIND_DUTY,
        POD_KIND_STATUS
    } pod_kind_t;

    // Result of an address decode.
    typedef struct packed {
        logic hit;
        logic ch;
        pod_kind_t kind;
    } pod_dec_t;

    // Divider channel state.
    typedef enum logic [1:0] {
        POD_ST_DELAY,
        POD_ST_HIGH,
        POD_ST_LOW
    } pod_state_t;

    // Phase settings captured by a synchronisation.
    typedef struct packed {
        logic begin_high;
        logic [3:0] phase_offset_field;
    } pod_phase_t;

endpackage

// File: pod_divider.sv
// Two channel dividers with high/low counts, bypass, duty correction and synced phase offset, behind AHB-Lite.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Four-bit low and high counts; output low M+1, high N+1 input cycles.
// - Counting uses edges of the clock routed to the divider input.
// - Bypass passes the divider input straight through, division one.
// - Unbypassed division ratio is N+M+2, covering two to thirty-two.
// - Duty correction is on after reset; each divider disables its own.
// - Uncorrected unbypassed high fraction is (N+1)/(N+M+2).
// - Bypass after odd prescaler gives 33.3%/40% uncorrected, 50% corrected; here bypass ignores correction and passes the input duty.
// - Bypass after prescaler 3 or 5 corrected yields (1+X)/3 or (2+X)/5; here bypass keeps the input duty with correction on.
// - Bypass keeps input duty; odd corrected ratio gives (N+1+X)/(2N+3).
// - Direct routing keeps source duty cycle unchanged.
// - Phase offset delays the output rise by whole input rising edges.
// - Delay comes from offset field and begin-high bit, plus low count.
// - Low count in bits 7:4, high count in 3:0, stored as count minus one.
// - Bypass is bit 7 of bypass register; correction-disable bit 0 of duty register.
// - Begin-high is bit 4, phase offset bits 3:0 of the bypass register.
// - Value up to 15 delays that many; else value minus 16 plus M plus 1.
// - The upstream prescaler divides by 2 to 6.
module pod_divider #(
    parameter int NCH = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic div_in,
    input wire logic sync_req,
    output logic [NCH-1:0] div_out
);
    import pod_pkg::*;

    // The register map holds exactly two dividers.
    if (NCH != 2) begin : g_bad_nch
        $error("pod_divider supports only two channels");
    end

    // ------------------------------------------------------------
    // Address decode and helper functions
    // ------------------------------------------------------------
    function automatic pod_dec_t pod_decode(input logic [31:0] addr);
        pod_dec_t d;
        d = '{hit: 1'b1, ch: 1'b0, kind: POD_KIND_STATUS};
        unique case (addr[31:2])
            POD_IDX_DIV0_CYCLE_COUNTS: d.kind = POD_KIND_COUNTS;
            POD_IDX_DIV0_BYPASS_CTRL: d.kind = POD_KIND_BYPASS;
            POD_IDX_DIV0_DUTY_FIX_CTRL: d.kind = POD_KIND_DUTY;
            POD_IDX_DIV1_CYCLE_COUNTS: d = '{hit: 1'b1, ch: 1'b1, kind: POD_KIND_COUNTS};
            POD_IDX_DIV1_BYPASS_CTRL: d = '{hit: 1'b1, ch: 1'b1, kind: POD_KIND_BYPASS};
            POD_IDX_DIV1_DUTY_FIX_CTRL: d = '{hit: 1'b1, ch: 1'b1, kind: POD_KIND_DUTY};
            POD_IDX_STATUS: d.kind = POD_KIND_STATUS;
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction

    // Offsets of 16 and up also wait out the programmed low count.
    function automatic logic [4:0] pod_delay(input pod_phase_t p, input logic [3:0] low_cnt);
        if (p.begin_high) begin
            return {1'b0, p.phase_offset_field} + {1'b0, low_cnt} + POD_CNT_ONE;
        end
        return {1'b0, p.phase_offset_field};
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic [7:0] counts_ff [NCH];
    logic [7:0] bypass_ff [NCH];
    logic [7:0] duty_ff [NCH];
    pod_state_t state_ff [NCH];
    logic wr_pend_ff;
    pod_dec_t wr_dec_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [31:0] hrdata_ff;
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] running;
    logic addr_ok;
    pod_dec_t a_dec;
    logic [7:0] rd_byte;

    assign addr_ok = hsel && hready && (htrans == POD_HTRANS_NONSEQ) && (hsize == POD_HSIZE_WORD);
    assign a_dec = pod_decode(haddr);

    // A read right behind a write to the same register sees the new byte.
    always_comb begin
        rd_byte = 8'h00;
        if (wr_pend_ff && wr_dec_ff == a_dec && a_dec.kind != POD_KIND_STATUS) begin
            rd_byte = hwdata[POD_REG_W-1:0];
        end else if (a_dec.hit) begin
            unique case (a_dec.kind)
                POD_KIND_COUNTS: rd_byte = counts_ff[a_dec.ch];
                POD_KIND_BYPASS: rd_byte = bypass_ff[a_dec.ch];
                POD_KIND_DUTY: rd_byte = duty_ff[a_dec.ch];
                POD_KIND_STATUS: rd_byte = {4'h0, running, out_ff};
            endcase
        end
    end

    // Capture the address phase; slave never inserts wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_dec_ff <= '0;
            hrdata_ff <= '0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= POD_HRESP_OKAY;
        end else begin
            wr_pend_ff <= addr_ok && hwrite && a_dec.hit && a_dec.kind != POD_KIND_STATUS;
            wr_dec_ff <= a_dec;
            hrdata_ff <= (addr_ok && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= POD_HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign div_out = out_ff;

    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    logic in_s1_ff, in_s2_ff, in_s3_ff;
    logic sy_s1_ff, sy_s2_ff, sy_s3_ff;
    logic start_ff;
    logic in_rise, in_fall, sync_go;

    // Three flops per pin; edges are judged from the second and third only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {in_s1_ff, in_s2_ff, in_s3_ff} <= 3'h0;
            {sy_s1_ff, sy_s2_ff, sy_s3_ff} <= 3'h0;
        end else begin
            {in_s1_ff, in_s2_ff, in_s3_ff} <= {div_in, in_s1_ff, in_s2_ff};
            {sy_s1_ff, sy_s2_ff, sy_s3_ff} <= {sync_req, sy_s1_ff, sy_s2_ff};
        end
    end

    // A synchronisation is issued automatically once after reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_ff <= 1'b1;
        end else begin
            start_ff <= 1'b0;
        end
    end

    // Only routed rises are counted, so any prescaler ratio ahead of the pin is served alike.
    assign in_rise = in_s2_ff && !in_s3_ff;
    assign in_fall = !in_s2_ff && in_s3_ff;
    assign sync_go = start_ff || (sy_s2_ff && !sy_s3_ff);

    // ------------------------------------------------------------
    // Channel dividers
    // ------------------------------------------------------------
    logic [4:0] cnt_ff [NCH];
    logic [NCH-1:0] pend_ff;
    pod_phase_t phase_ff [NCH];
    logic [3:0] hi_n [NCH];
    logic [3:0] lo_m [NCH];
    logic [NCH-1:0] byp, corr;
    logic [4:0] dly [NCH];

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // Register writes land in the data phase, low byte only.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                counts_ff[c] <= POD_RST_CYCLE_COUNTS;
                bypass_ff[c] <= POD_RST_BYPASS_CTRL;
                duty_ff[c] <= POD_RST_DUTY_FIX_CTRL;
            end else if (wr_pend_ff && wr_dec_ff.ch == 1'(c)) begin
                unique case (wr_dec_ff.kind)
                    POD_KIND_COUNTS: counts_ff[c] <= hwdata[POD_REG_W-1:0];
                    POD_KIND_BYPASS: bypass_ff[c] <= hwdata[POD_REG_W-1:0];
                    POD_KIND_DUTY: duty_ff[c] <= hwdata[POD_REG_W-1:0];
                    POD_KIND_STATUS: ;
                endcase
            end
        end

        assign hi_n[c] = counts_ff[c][POD_FLD_HIGH_LSB +: POD_FLD_W];
        assign lo_m[c] = counts_ff[c][POD_FLD_LOW_LSB +: POD_FLD_W];
        assign byp[c] = bypass_ff[c][POD_BIT_BYPASS];
        // Correction only matters for odd ratios; even ones with M=N are already 50%.
        assign corr[c] = !duty_ff[c][POD_BIT_CORR_DIS] && (hi_n[c][0] ^ lo_m[c][0]);
        assign dly[c] = pod_delay(phase_ff[c], lo_m[c]);
        assign running[c] = state_ff[c] != POD_ST_DELAY;

        // Phase settings are only sampled at a synchronisation.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                phase_ff[c] <= '0;
            end else if (sync_go) begin
                phase_ff[c] <= '{begin_high: bypass_ff[c][POD_BIT_BEGIN_HIGH],
                                 phase_offset_field: bypass_ff[c][POD_FLD_PHASE_LSB +: POD_FLD_W]};
            end
        end

        // Delay, then alternate high and low phases counted on input rises.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                state_ff[c] <= POD_ST_DELAY;
                cnt_ff[c] <= POD_CNT_ZERO;
                pend_ff[c] <= 1'b0;
                out_ff[c] <= 1'b0;
            end else if (sync_go) begin
                state_ff[c] <= POD_ST_DELAY;
                cnt_ff[c] <= POD_CNT_ZERO;
                pend_ff[c] <= 1'b0;
                out_ff[c] <= 1'b0;
            end else if (byp[c]) begin
                out_ff[c] <= in_s2_ff;
            end else begin
                unique case (state_ff[c])
                    POD_ST_DELAY: begin
                        if (in_rise && cnt_ff[c] == dly[c]) begin
                            out_ff[c] <= 1'b1;
                            state_ff[c] <= POD_ST_HIGH;
                            cnt_ff[c] <= POD_CNT_ZERO;
                        end else if (in_rise) begin
                            cnt_ff[c] <= cnt_ff[c] + POD_CNT_ONE;
                        end
                    end
                    POD_ST_HIGH: begin
                        if (in_rise && cnt_ff[c] == {1'b0, hi_n[c]}) begin
                            // Under correction the fall waits for the input's own falling edge.
                            state_ff[c] <= POD_ST_LOW;
                            cnt_ff[c] <= POD_CNT_ZERO;
                            pend_ff[c] <= corr[c];
                            out_ff[c] <= corr[c];
                        end else if (in_rise) begin
                            cnt_ff[c] <= cnt_ff[c] + POD_CNT_ONE;
                        end
                    end
                    POD_ST_LOW: begin
                        if (in_rise && cnt_ff[c] == {1'b0, lo_m[c]}) begin
                            state_ff[c] <= POD_ST_HIGH;
                            cnt_ff[c] <= POD_CNT_ZERO;
                            out_ff[c] <= 1'b1;
                            pend_ff[c] <= 1'b0;
                        end else begin
                            if (in_rise) begin
                                cnt_ff[c] <= cnt_ff[c] + POD_CNT_ONE;
                            end
                            if (pend_ff[c] && in_fall) begin
                                out_ff[c] <= 1'b0;
                                pend_ff[c] <= 1'b0;
                            end
                        end
                    end
                endcase
            end
        end

        // ------------------------------------------------------------
        // Assertions
        // ------------------------------------------------------------
        sequence s_high_end;
            !sync_go && !byp[c] && state_ff[c] == POD_ST_HIGH && in_rise && cnt_ff[c] == {1'b0, hi_n[c]};
        endsequence

        sequence s_low_end;
            !sync_go && !byp[c] && state_ff[c] == POD_ST_LOW && in_rise && cnt_ff[c] == {1'b0, lo_m[c]};
        endsequence

        property p_bypass_follow;
            @(posedge hclk) disable iff (!hresetn) !sync_go && byp[c] |=> out_ff[c] == $past(in_s2_ff);
        endproperty
        a_bypass_follow: assert property (p_bypass_follow) else $error("bypass output does not follow input");

        property p_high_falls;
            @(posedge hclk) disable iff (!hresetn) s_high_end ##0 !corr[c] |=> !out_ff[c] && state_ff[c] == POD_ST_LOW;
        endproperty
        a_high_falls: assert property (p_high_falls) else $error("high phase did not end after N+1 rises");

        property p_corr_fall;
            @(posedge hclk) disable iff (!hresetn)
                s_high_end ##0 corr[c] |=> out_ff[c] && pend_ff[c] && state_ff[c] == POD_ST_LOW;
        endproperty
        a_corr_fall: assert property (p_corr_fall) else $error("corrected fall came early");

        property p_pend_hold;
            @(posedge hclk) disable iff (!hresetn)
                !sync_go && !byp[c] && pend_ff[c] && state_ff[c] == POD_ST_LOW && !in_fall && !in_rise |=> out_ff[c];
        endproperty
        a_pend_hold: assert property (p_pend_hold) else $error("corrected high ended before input fall");

        property p_pend_fall;
            @(posedge hclk) disable iff (!hresetn) !sync_go && !byp[c] && pend_ff[c] && in_fall |=> !out_ff[c];
        endproperty
        a_pend_fall: assert property (p_pend_fall) else $error("pending fall missed input falling edge");

        property p_low_rises;
            @(posedge hclk) disable iff (!hresetn) s_low_end |=> out_ff[c] && state_ff[c] == POD_ST_HIGH;
        endproperty
        a_low_rises: assert property (p_low_rises) else $error("low phase did not end after M+1 rises");

        property p_delay_low;
            @(posedge hclk) disable iff (!hresetn) !byp[c] && state_ff[c] == POD_ST_DELAY |-> !out_ff[c];
        endproperty
        a_delay_low: assert property (p_delay_low) else $error("output high during offset delay");

        property p_delay_len;
            @(posedge hclk) disable iff (!hresetn)
                !sync_go && !byp[c] && state_ff[c] == POD_ST_DELAY && in_rise && cnt_ff[c] == dly[c] |=> out_ff[c];
        endproperty
        a_delay_len: assert property (p_delay_len) else $error("output rise not at programmed offset");

        property p_phase_held;
            @(posedge hclk) disable iff (!hresetn) !sync_go |=> $stable(phase_ff[c]);
        endproperty
        a_phase_held: assert property (p_phase_held) else $error("phase offset applied without sync");

        property p_sync_load;
            @(posedge hclk) disable iff (!hresetn)
                sync_go |=> state_ff[c] == POD_ST_DELAY &&
                    phase_ff[c] == $past(bypass_ff[c][POD_BIT_BEGIN_HIGH:POD_FLD_PHASE_LSB]);
        endproperty
        a_sync_load: assert property (p_sync_load) else $error("sync did not restart divider");

        property p_rise_cause;
            @(posedge hclk) disable iff (!hresetn) !$past(byp[c]) && !$past(sync_go) && $rose(out_ff[c]) |-> $past(in_rise);
        endproperty
        a_rise_cause: assert property (p_rise_cause) else $error("output rose without input rise");

        property p_write_counts;
            @(posedge hclk) disable iff (!hresetn)
                wr_pend_ff && wr_dec_ff.ch == 1'(c) && wr_dec_ff.kind == POD_KIND_COUNTS |=>
                    counts_ff[c] == $past(hwdata[POD_REG_W-1:0]);
        endproperty
        a_write_counts: assert property (p_write_counts) else $error("counts register not written");
    end

endmodule
`default_nettype wire

// File: pod_clk_src.sv
// Behavioural model of the routed clock that feeds the divider input.
`timescale 1ns/10ps
`default_nettype none
module pod_clk_src (
    input wire logic hclk,
    input wire logic run,
    input wire logic [3:0] hi_len,
    input wire logic [3:0] lo_len,
    output logic div_in
);
    // Known levels from time zero, so the sampler never sees an unknown.
    logic [3:0] cnt_ff = 4'h0;
    logic lvl_ff = 1'b0;
    // ------------------------------------------------
    // Clock generation
    // ------------------------------------------------
    // Whole hclk levels of at least two cycles keep every edge visible to the sampler.
    // The divider counts the cycles of this routed clock.
    always @(posedge hclk) begin
        if (!run) begin
            lvl_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (cnt_ff == 4'h0) begin
            lvl_ff <= !lvl_ff;
            cnt_ff <= (lvl_ff ? lo_len : hi_len) - 4'h1;
        end else begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    assign div_in = lvl_ff;
endmodule
`default_nettype wire

// File: paired_output_channel_divider_tb_top.sv
// Self-checking testbench for the paired output channel divider.
`timescale 1ns/10ps
`default_nettype none
module paired_output_channel_divider_tb_top;
    import pod_pkg::*;
    localparam logic [31:0] P = 32'h4;
    localparam logic [29:0] REGS [6] = '{POD_IDX_DIV0_CYCLE_COUNTS, POD_IDX_DIV0_BYPASS_CTRL,
        POD_IDX_DIV0_DUTY_FIX_CTRL, POD_IDX_DIV1_CYCLE_COUNTS, POD_IDX_DIV1_BYPASS_CTRL, POD_IDX_DIV1_DUTY_FIX_CTRL};
    // Each entry is channel, correction disable, high count, low count.
    // Corrected odd entries keep the low count one above the high count.
    localparam logic [9:0] CASES [6] = '{10'h101, 10'h3ff, 10'h130, 10'h012, 10'h222, 10'h100};
    localparam logic [7:0] PH_VAL [3] = '{8'h0f, 8'h11, 8'h10};
    localparam logic [31:0] PH_CYC [3] = '{32'd15, 32'd9, 32'd8};
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, sync_req, src_run, hreadyout, hresp, div_in;
    logic [31:0] haddr, hwdata, hrdata, v, hi_t, lo_t;
    logic [1:0] htrans, div_out;
    logic [2:0] hsize;
    logic [3:0] src_hi, src_lo;
    logic [9:0] c;
    int fails = 0;
    int check_count = 0;

    pod_divider #(.NCH(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .div_in(div_in), .sync_req(sync_req), .div_out(div_out));
    pod_clk_src src_u (.hclk(hclk), .run(src_run), .hi_len(src_hi), .lo_len(src_lo), .div_in(div_in));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    // Clock of 100 ns period.
    always #50 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits for an edge with hready high; a stuck bus counts as a mismatch.
    task automatic edge_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        check(n, 0);
    endtask

    // One single-word transfer; entered and left just after a rising edge.
    task automatic bus(input logic [29:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= POD_HTRANS_NONSEQ;
        hwrite <= wr;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, POD_HRESP_OKAY});
    endtask

    task automatic wr(input logic [29:0] idx, input logic [31:0] wd);
        logic [31:0] t;
        bus(idx, 1'b1, wd, t);
    endtask

    // Counts edges until the output reaches the level; bounded.
    task automatic wait_lvl(input int ch, input logic lvl, output logic [31:0] len);
        len = 32'h0;
        while (div_out[ch] !== lvl && len < 32'd600) begin
            @(posedge hclk);
            len = len + 32'h1;
        end
        if (len == 32'd600) check(len, 32'h0);
    endtask

    // Skips a settling period, then measures one high and one low phase.
    task automatic measure(input int ch, output logic [31:0] hi, output logic [31:0] lo);
        logic [31:0] t;
        repeat (2) begin
            wait_lvl(ch, 1'b0, t);
            wait_lvl(ch, 1'b1, t);
        end
        wait_lvl(ch, 1'b0, hi);
        wait_lvl(ch, 1'b1, lo);
    endtask

    // Edges from the first output's rise to the second output's rise.
    task automatic skew(input logic do_sync, output logic [31:0] d);
        logic [31:0] t;
        // Three edges reach the one that takes the sync, so the first rise after it is measured.
        if (do_sync) begin
            sync_req <= 1'b1;
            repeat (3) @(posedge hclk);
            sync_req <= 1'b0;
        end
        wait_lvl(0, 1'b0, t);
        wait_lvl(0, 1'b1, t);
        wait_lvl(1, 1'b1, d);
    endtask

    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    // The whole sequence needs well under ten thousand cycles.
    initial begin
        repeat (40000) @(posedge hclk);
        fails++;
        report_and_stop();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = POD_HSIZE_WORD;
        hwdata = 32'h0;
        sync_req = 1'b0;
        src_run = 1'b0;
        src_hi = 4'h2;
        src_lo = 4'h2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 6; i++) begin
            bus(REGS[i], 1'b0, 32'h0, v);
            check(v, 32'h0);
            wr(REGS[i], 32'hffffff5a);
            bus(REGS[i], 1'b0, 32'h0, v);
            check(v, 32'h5a);
            wr(REGS[i], 32'h0);
        end
        wr(30'h193, 32'hff);
        bus(30'h193, 1'b0, 32'h0, v);
        check(v, 32'h0);
        // Status ignores writes; with no input both channels still wait in their delay.
        wr(POD_IDX_STATUS, 32'hff);
        bus(POD_IDX_STATUS, 1'b0, 32'h0, v);
        check(v, 32'h0);
        src_run <= 1'b1;
        // Ratios and duty on either channel; correction on channel 0.
        for (int i = 0; i < 6; i++) begin
            c = CASES[i];
            wr(POD_IDX_DIV0_CYCLE_COUNTS + (c[9] ? 30'h6 : 30'h0), {24'h0, c[3:0], c[7:4]});
            wr(POD_IDX_DIV0_DUTY_FIX_CTRL + (c[9] ? 30'h6 : 30'h0), {31'h0, c[8]});
            measure(c[9], hi_t, lo_t);
            v = (!c[8] && (c[4] ^ c[0])) ? {28'h0, src_hi} : 32'h0;
            check(hi_t, ({28'h0, c[7:4]} + 32'h1) * P + v);
            check(lo_t, ({28'h0, c[3:0]} + 32'h1) * P - v);
        end
        bus(POD_IDX_STATUS, 1'b0, 32'h0, v);
        check(v & 32'hc, 32'hc);
        // Bypass keeps the input's own duty even with correction on.
        wr(POD_IDX_DIV0_DUTY_FIX_CTRL, 32'h0);
        wr(POD_IDX_DIV0_BYPASS_CTRL, 32'h80);
        src_hi <= 4'h3;
        measure(0, hi_t, lo_t);
        check(hi_t, 32'h3);
        check(lo_t, 32'h2);
        src_hi <= 4'h2;
        // Phase offsets between two channels of ratio sixteen.
        for (int i = 0; i < 6; i++) begin
            wr(REGS[i], (i % 3 == 0) ? 32'h77 : ((i % 3 == 2) ? 32'h1 : 32'h0));
        end
        skew(1'b1, v);
        check(v, 32'h0);
        wr(POD_IDX_DIV1_BYPASS_CTRL, 32'h03);
        skew(1'b0, v);
        check(v, 32'h0);
        skew(1'b1, v);
        check(v, 32'h3 * P);
        for (int i = 0; i < 3; i++) begin
            wr(POD_IDX_DIV1_BYPASS_CTRL, {24'h0, PH_VAL[i]});
            skew(1'b1, v);
            check(v, PH_CYC[i] * P);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
